// ===== hw/cit_timer.sv
`timescale 1ns/100ps
module cit_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclk_en,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic timer_output_pin,
  output logic low_channel_irq_flag
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RESP
  } cit_wr_state_t;

  typedef struct packed {
    cit_pkg::cit_regs_t regs;
    logic [7:0] low_counter;
    logic [7:0] high_counter;
    logic irq;
    logic toggle;
    logic pin;
    logic aw_got;
    logic w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic wstrb0;
    cit_wr_state_t wst;
    cit_pkg::cit_axi_out_t axi;
  } cit_state_t;

  cit_state_t r;
  cit_state_t next_r;
  logic [cit_pkg::PRE_WIDTH:0] tick;

  cit_prescaler #(
    .WIDTH(cit_pkg::PRE_WIDTH)
  ) u_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .aclk_en(aclk_en),
    .tick(tick)
  );

  function automatic logic low_pulse(
    input logic [2:0] sel,
    input logic [cit_pkg::PRE_WIDTH:0] t
  );
    logic p;
    p = 1'b0;
    unique case (sel)
      cit_pkg::SEL_OVF: p = t[1];
      cit_pkg::SEL_C3: p = t[0];
      cit_pkg::SEL_C4: p = t[10];
      cit_pkg::SEL_C5: p = t[8];
      cit_pkg::SEL_C6: p = t[6];
      cit_pkg::SEL_C7: p = t[4];
      default: p = 1'b0;
    endcase
    return p;
  endfunction

  function automatic logic high_pulse(
    input logic [2:0] sel,
    input logic ovf,
    input logic [cit_pkg::PRE_WIDTH:0] t
  );
    logic p;
    p = 1'b0;
    unique case (sel)
      cit_pkg::SEL_OVF: p = ovf;
      cit_pkg::SEL_C3: p = t[5];
      cit_pkg::SEL_C4: p = t[12];
      cit_pkg::SEL_C5: p = t[10];
      cit_pkg::SEL_C6: p = t[8];
      cit_pkg::SEL_C7: p = t[6];
      default: p = 1'b0;
    endcase
    return p;
  endfunction

  always_comb begin
    logic cascade;
    logic run;
    logic lp;
    logic ovf;
    logic hp;
    logic match_lo;
    logic match_hi;
    logic joint;
    logic start_lo;
    logic start_hi;
    logic do_write;
    logic [31:0] rd;
    logic hit;
    logic flag_set;
    logic rd_status;
    logic out_en;

    cascade = 1'b0;
    run = 1'b0;
    lp = 1'b0;
    ovf = 1'b0;
    hp = 1'b0;
    match_lo = 1'b0;
    match_hi = 1'b0;
    joint = 1'b0;
    start_lo = 1'b0;
    start_hi = 1'b0;
    do_write = 1'b0;
    rd = '0;
    hit = 1'b1;
    flag_set = 1'b0;
    rd_status = 1'b0;
    out_en = 1'b0;
    next_r = r;

    cascade = (r.regs.low_mode[cit_pkg::MODE_SEL_LSB +: 2]
               == cit_pkg::MODE_CASCADE) &&
              (r.regs.high_mode[cit_pkg::MODE_SEL_LSB +: 2]
               == cit_pkg::MODE_CASCADE);
    run = cascade && r.regs.low_mode[cit_pkg::RUN_BIT];
    lp = run && low_pulse(r.regs.low_mode[cit_pkg::CLK_SEL_LSB +: 3],
                          tick);
    match_lo = (r.low_counter == r.regs.low_mod);
    match_hi = (r.high_counter == r.regs.high_mod);
    joint = match_lo && match_hi;
    ovf = lp && (r.low_counter == 8'hFF);
    hp = run && high_pulse(r.regs.high_mode[cit_pkg::CLK_SEL_LSB +: 3],
                           ovf, tick);
    flag_set = lp && joint;

    if (aclk_en) begin
      if (lp) begin
        if (joint) begin
          next_r.low_counter = 8'h00;
          next_r.high_counter = 8'h00;
          next_r.irq = 1'b1;
          next_r.toggle = ~r.toggle;
        end else begin
          next_r.low_counter = r.low_counter + 8'h01;
          if (hp) begin
            next_r.high_counter = r.high_counter + 8'h01;
          end
        end
      end else if (hp) begin
        next_r.high_counter = r.high_counter + 8'h01;
      end

      // axi write channel capture
      if (s_axi_awvalid && r.axi.awready) begin
        next_r.aw_got = 1'b1;
        next_r.awaddr = s_axi_awaddr;
        next_r.axi.awready = 1'b0;
      end
      if (s_axi_wvalid && r.axi.wready) begin
        next_r.w_got = 1'b1;
        next_r.wdata = s_axi_wdata;
        next_r.wstrb0 = s_axi_wstrb[0];
        next_r.axi.wready = 1'b0;
      end
      unique case (r.wst)
        ST_IDLE: begin
          do_write = r.aw_got && r.w_got;
        end
        ST_RESP: begin
          if (s_axi_bready) begin
            next_r.axi.bvalid = 1'b0;
            next_r.axi.awready = 1'b1;
            next_r.axi.wready = 1'b1;
            next_r.wst = ST_IDLE;
          end
        end
      endcase

      if (do_write) begin
        next_r.aw_got = 1'b0;
        next_r.w_got = 1'b0;
        next_r.axi.bvalid = 1'b1;
        next_r.axi.bresp = cit_pkg::RESP_OKAY;
        next_r.wst = ST_RESP;
        if (r.wstrb0) begin
          unique case (r.awaddr)
            cit_pkg::LOW_MODE_ADDR: begin
              next_r.regs.low_mode = {1'b0, r.wdata[6:0]};
              start_lo = r.wdata[cit_pkg::START_BIT];
            end
            cit_pkg::HIGH_MODE_ADDR: begin
              next_r.regs.high_mode = {1'b0, r.wdata[6:0]};
              start_hi = r.wdata[cit_pkg::START_BIT];
            end
            cit_pkg::CTRL_ADDR: begin
              next_r.regs.ctrl = r.wdata[7:0];
            end
            cit_pkg::HIGH_MOD_ADDR: begin
              next_r.regs.high_mod = r.wdata[7:0];
            end
            cit_pkg::LOW_MOD_ADDR: begin
              next_r.regs.low_mod = r.wdata[7:0];
            end
            cit_pkg::COUNT_ADDR, cit_pkg::STATUS_ADDR: begin
              // read-only, write ignored
              hit = 1'b1;
            end
            default: hit = 1'b0;
          endcase
        end
        if (!hit) begin
          next_r.axi.bresp = cit_pkg::RESP_SLVERR;
        end
      end

      if (start_lo) begin
        next_r.low_counter = 8'h00;
        next_r.irq = 1'b0;
      end
      if (start_hi) begin
        next_r.high_counter = 8'h00;
      end
      next_r.regs.low_mode[cit_pkg::START_BIT] = 1'b0;
      next_r.regs.high_mode[cit_pkg::START_BIT] = 1'b0;

      // axi read channel
      if (r.axi.rvalid) begin
        if (s_axi_rready) begin
          next_r.axi.rvalid = 1'b0;
          next_r.axi.arready = 1'b1;
        end
      end else if (s_axi_arvalid && r.axi.arready) begin
        next_r.axi.arready = 1'b0;
        next_r.axi.rvalid = 1'b1;
        next_r.axi.rresp = cit_pkg::RESP_OKAY;
        unique case (s_axi_araddr)
          cit_pkg::LOW_MODE_ADDR: rd = {24'h0, r.regs.low_mode};
          cit_pkg::HIGH_MODE_ADDR: rd = {24'h0, r.regs.high_mode};
          cit_pkg::CTRL_ADDR: rd = {24'h0, r.regs.ctrl};
          cit_pkg::HIGH_MOD_ADDR: rd = {24'h0, r.regs.high_mod};
          cit_pkg::LOW_MOD_ADDR: rd = {24'h0, r.regs.low_mod};
          cit_pkg::COUNT_ADDR: rd = {16'h0, r.high_counter, r.low_counter};
          cit_pkg::STATUS_ADDR: rd = {29'h0, cascade, r.toggle, r.irq};
          default: begin
            rd = '0;
            next_r.axi.rresp = cit_pkg::RESP_SLVERR;
          end
        endcase
        next_r.axi.rdata = rd;
        // flag cleared by reading status
        // status read clears flag; set wins
        rd_status = (s_axi_araddr == cit_pkg::STATUS_ADDR);
        if (rd_status && !flag_set) begin
          next_r.irq = 1'b0;
        end
      end

      out_en = r.regs.ctrl[cit_pkg::OUT_EN_BIT];
      next_r.pin = out_en && next_r.toggle;
    end

    if (!aresetn) begin
      next_r = '0;
      next_r.regs.low_mode = cit_pkg::MODE_RESET;
      next_r.regs.high_mode = cit_pkg::MODE_RESET;
      next_r.regs.ctrl = cit_pkg::CTRL_RESET;
      next_r.regs.high_mod = cit_pkg::MODULO_RESET;
      next_r.regs.low_mod = cit_pkg::MODULO_RESET;
      next_r.wst = ST_IDLE;
      next_r.axi.awready = 1'b1;
      next_r.axi.wready = 1'b1;
      next_r.axi.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    r <= next_r;
  end

  assign s_axi_awready = r.axi.awready;
  assign s_axi_wready = r.axi.wready;
  assign s_axi_bvalid = r.axi.bvalid;
  assign s_axi_bresp = r.axi.bresp;
  assign s_axi_arready = r.axi.arready;
  assign s_axi_rvalid = r.axi.rvalid;
  assign s_axi_rdata = r.axi.rdata;
  assign s_axi_rresp = r.axi.rresp;
  assign timer_output_pin = r.pin;
  assign low_channel_irq_flag = r.irq;
endmodule

// ===== hw/cit_pkg.sv
package cit_pkg;
  // register byte addresses (printed offsets are multiples of four)
  localparam logic [11:0] LOW_MODE_ADDR = 12'hF90;
  localparam logic [11:0] HIGH_MODE_ADDR = 12'hFA8;
  localparam logic [11:0] CTRL_ADDR = 12'hFB0;
  localparam logic [11:0] HIGH_MOD_ADDR = 12'hFB4;
  localparam logic [11:0] LOW_MOD_ADDR = 12'hFB8;
  localparam logic [11:0] COUNT_ADDR = 12'hFBC;
  localparam logic [11:0] STATUS_ADDR = 12'hFC0;
  // mode register fields
  localparam int MODE_SEL_LSB = 0;
  localparam int RUN_BIT = 2;
  localparam int START_BIT = 3;
  localparam int CLK_SEL_LSB = 4;
  localparam logic [1:0] MODE_CASCADE = 2'h2;
  // control register fields
  localparam int OUT_EN_BIT = 0;
  // reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MODULO_RESET = 8'hFF;
  // clock-select codes
  localparam logic [2:0] SEL_OVF = 3'h2;
  localparam logic [2:0] SEL_C3 = 3'h3;
  localparam logic [2:0] SEL_C4 = 3'h4;
  localparam logic [2:0] SEL_C5 = 3'h5;
  localparam logic [2:0] SEL_C6 = 3'h6;
  localparam logic [2:0] SEL_C7 = 3'h7;
  // prescaler tap exponents
  localparam int PRE_WIDTH = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] low_mode;
    logic [7:0] high_mode;
    logic [7:0] ctrl;
    logic [7:0] high_mod;
    logic [7:0] low_mod;
  } cit_regs_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cit_axi_out_t;
endpackage

// ===== hw/cit_prescaler.sv
`timescale 1ns/100ps
// free-running divider; tick[k] pulses once every 2^k clocks
module cit_prescaler #(
  parameter int WIDTH = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclk_en,
  output logic [WIDTH:0] tick
);
  logic [WIDTH-1:0] count;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
    end else if (aclk_en) begin
      count <= count + 1'b1;
    end
  end

  assign tick[0] = aclk_en;
  genvar k;
  generate
    for (k = 1; k <= WIDTH; k++) begin : g_tap
      assign tick[k] = aclk_en && (count[k-1:0] == '1);
    end
  endgenerate
endmodule

// ===== dv/cit_timer_assertions.sv
`timescale 1ns/100ps
module cit_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclk_en,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_output_pin,
  input wire logic low_channel_irq_flag
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_done;
    s_axi_bvalid && s_axi_bready && aclk_en;
  endsequence
  property p_wr_lat;
    s_wr_take ##0 aclk_en |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat)
    else $error("write response timing wrong");
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready && aclk_en |=> s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read data late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped");
  property p_b_done;
    s_b_done |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
  endproperty
  a_b_done: assert property (p_b_done)
    else $error("write channel not freed");
  property p_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_busy: assert property (p_busy)
    else $error("ready while response pending");
  property p_rhi;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_rhi: assert property (p_rhi)
    else $error("upper read bits set");
  property p_rst;
    $rose(aresetn) |-> s_axi_awready && s_axi_arready && !s_axi_bvalid
      && !s_axi_rvalid && !timer_output_pin && !low_channel_irq_flag;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not idle after reset");
endmodule
bind cit_timer cit_chk u_chk (.*);

// ===== dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic aclk_en = 1'h1;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, timer_output_pin, low_channel_irq_flag;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rv;
  logic [7:0] mdl [logic [11:0]];
  logic [11:0] ra [7] = '{cit_pkg::LOW_MODE_ADDR, cit_pkg::HIGH_MODE_ADDR,
    cit_pkg::CTRL_ADDR, cit_pkg::HIGH_MOD_ADDR, cit_pkg::LOW_MOD_ADDR,
    cit_pkg::COUNT_ADDR, cit_pkg::STATUS_ADDR};
  logic [31:0] seed = 32'h00013407;
  int error_cnt = 0;
  int compares = 0;
  cit_timer dut (.*);
  always #25 aclk = ~aclk;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
      input logic [3:0] s = 4'hF, input logic [1:0] r = 2'h0);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= (rnd() << 8) | {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do @(posedge aclk); while (s_axi_awready !== 1'h1);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    chk(s_axi_bresp, r);
    s_axi_bready <= 1'h1;
    @(posedge aclk);
    s_axi_bready <= 1'h0;
    if (s[0] && r == 2'h0)
      mdl[a] = (a == ra[0] || a == ra[1]) ? d & 8'h77 : d;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e,
      input logic [31:0] m = 32'hFFFFFFFF, input logic [1:0] r = 2'h0);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h1;
    @(posedge aclk);
    s_axi_rready <= 1'h0;
    rv = s_axi_rdata;
    chk(rv & m, e);
    chk(s_axi_rresp, r);
  endtask
  task automatic period(output int n);
    logic p;
    @(posedge aclk);
    p = timer_output_pin;
    do @(posedge aclk); while (timer_output_pin === p);
    p = timer_output_pin;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (timer_output_pin === p);
  endtask
  initial begin
    #(50 * 20000);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    int n, lm, hm, sel;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < 5; i++) begin
      mdl[ra[i]] = (i < 3) ? 8'h00 : cit_pkg::MODULO_RESET;
      rc(ra[i], {24'h0, mdl[ra[i]]});
    end
    rc(ra[6], 32'h0);
    rc(12'hFC4, 32'h0, 32'hFFFFFFFF, 2'h2);
    wr(ra[2], 8'h01, 4'h0);
    rc(ra[2], 32'h0);
    wr(12'hFC4, 8'h5A, 4'hF, 2'h2);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      lm = rnd() % 15 + 1;
      hm = (i == 1);
      sel = (i == 2) ? 2 : 3;
      wr(ra[3], hm[7:0]);
      wr(ra[4], lm[7:0]);
      wr(ra[2], 8'h01, 4'h1);
      wr(ra[1], 8'h2A);
      wr(ra[0], {1'h0, sel[2:0], 4'hE});
      rc(ra[0], {24'h0, mdl[ra[0]]});
      period(n);
      chk(n, (hm * 256 + lm + 1) * (4 - sel));
      period(n);
      chk(n, (hm * 256 + lm + 1) * (4 - sel));
      rc(ra[6], 32'h5, 32'h5);
    end
    $display("test interval done");
    aclk_en <= 1'h0;
    @(posedge aclk);
    rv = {30'h0, low_channel_irq_flag, timer_output_pin};
    repeat (40) begin
      @(posedge aclk);
      chk({30'h0, low_channel_irq_flag, timer_output_pin}, rv);
    end
    aclk_en <= 1'h1;
    $display("test clock enable done");
    wr(ra[2], 8'h00);
    repeat (40) begin
      @(posedge aclk);
      chk(timer_output_pin, 1'h0);
    end
    $display("test output enable done");
    wr(ra[0], 8'h32);
    rc(ra[5], 32'h0, 32'h0);
    n = rv;
    repeat (20) @(posedge aclk);
    rc(ra[5], n);
    $display("test hold done");
    wr(ra[0], 8'h3A);
    rc(ra[5], 32'h0, 32'hFF);
    rc(ra[6], 32'h0, 32'h1);
    $display("test start done");
    wr(ra[0], 8'h06);
    repeat (20) @(posedge aclk);
    rc(ra[5], 32'h0, 32'hFF);
    wr(ra[0], 8'h35);
    repeat (20) @(posedge aclk);
    rc(ra[5], 32'h0, 32'hFF);
    rc(ra[6], 32'h0, 32'h4);
    $display("test mode select done");
    tally_and_finish();
  end
endmodule
